/* File: uhp_consts.svh */
`ifndef UHP_CONSTS_SVH
`define UHP_CONSTS_SVH
// Register indices within one channel, selected by the three address inputs.
`define UHP_ADDR_DATA   3'h0
`define UHP_ADDR_IER    3'h1
`define UHP_ADDR_IIR    3'h2
`define UHP_ADDR_LCR    3'h3
`define UHP_ADDR_MCR    3'h4
`define UHP_ADDR_LSR    3'h5
`define UHP_ADDR_MSR    3'h6
`define UHP_ADDR_SCR    3'h7
// Field positions.
`define UHP_MCR_DTR_BIT 0
`define UHP_MCR_IRQ_BIT 3
`define UHP_IER_RX_BIT  0
`define UHP_IER_TX_BIT  1
`define UHP_IER_LS_BIT  2
`define UHP_IER_MS_BIT  3
`define UHP_MSR_DDSR_BIT 1
`define UHP_MSR_DSR_BIT 5
// Reset values.
`define UHP_IER_RST     8'h00
`define UHP_MCR_RST     8'h00
`define UHP_SCR_RST     8'h00
`define UHP_LCR_RST     8'h00
// Interrupt identification codes, highest priority first.
`define UHP_IIR_NONE    8'h01
`define UHP_IIR_LS      8'h06
`define UHP_IIR_RX      8'h04
`define UHP_IIR_TX      8'h02
`define UHP_IIR_MS      8'h00
`endif

/* File: uhp_pkg.sv */
package uhp_pkg;
  typedef logic [7:0] uhp_byte_t;
  typedef logic [2:0] uhp_addr_t;
  typedef enum logic [1:0] {
    UHP_IDLE  = 2'b00,
    UHP_READ  = 2'b01,
    UHP_WRITE = 2'b10
  } uhp_bus_e;
endpackage

/* File: uhp_chan_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface uhp_chan_if;
  logic             wr_stb;
  logic [2:0]       addr;
  logic [7:0]       wdata;
  logic [7:0]       rdata;
  logic             rd_stb;
  logic             irq;
  logic             irq_oe_n;
  logic             dtr_n;
  modport host (output wr_stb, output rd_stb, output addr, output wdata,
                input rdata, input irq, input irq_oe_n, input dtr_n);
  modport chan (input wr_stb, input rd_stb, input addr, input wdata,
                output rdata, output irq, output irq_oe_n, output dtr_n);
endinterface
`default_nettype wire

/* File: uhp_channel.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uhp_consts.svh"
module uhp_channel (
  input  wire logic  clk,          // Clock.
  input  wire logic  rst_n,        // Synchronised reset.
  uhp_chan_if.chan   bus,          // Register access from the host port.
  input  wire logic  set_ready_n,  // Modem ready input, active low.
  input  wire logic  rx_err,       // Receiver error event.
  input  wire logic  rx_avail,     // Receive data available level.
  input  wire logic  tx_space      // Transmit space available level.
);
  logic [7:0] ier_q, mcr_q, scr_q, lcr_q;
  logic       dsr_q, ddsr_q, ls_q, tx_q, tx_lvl_q;
  logic       ms_set, ls_set, ls_clr, ms_clr, tx_clr, tx_set;
  logic [7:0] iir_w, msr_w, lsr_w, rd_w;
  logic       ls_p, rx_p, tx_p, ms_p, pend;

  ////////////////////////////////////////////////////////////////////////////
  assign ms_set = dsr_q != ~set_ready_n;
  assign ls_set = rx_err;
  // Only a rising edge of transmit space sets the flag, so that a clear holds while space lasts.
  assign tx_set = tx_space & ~tx_lvl_q;
  assign ls_clr = bus.rd_stb && bus.addr == `UHP_ADDR_LSR;
  assign ms_clr = bus.rd_stb && bus.addr == `UHP_ADDR_MSR;
  assign tx_clr = (bus.rd_stb && bus.addr == `UHP_ADDR_IIR && iir_w == `UHP_IIR_TX) ||
                  (bus.wr_stb && bus.addr == `UHP_ADDR_DATA);
  // Enabled sources: errors, data available, transmit space, modem change.
  assign ls_p = ls_q & ier_q[`UHP_IER_LS_BIT];
  assign rx_p = rx_avail & ier_q[`UHP_IER_RX_BIT];
  assign tx_p = tx_q & ier_q[`UHP_IER_TX_BIT];
  assign ms_p = ddsr_q & ier_q[`UHP_IER_MS_BIT];
  assign pend = ls_p | rx_p | tx_p | ms_p;
  assign iir_w = ls_p ? `UHP_IIR_LS : rx_p ? `UHP_IIR_RX : tx_p ? `UHP_IIR_TX :
                 ms_p ? `UHP_IIR_MS : `UHP_IIR_NONE;
  assign msr_w = {2'b00, dsr_q, 3'b000, ddsr_q, 1'b0};
  assign lsr_w = {1'b0, tx_space, tx_space, 3'b000, ls_q, rx_avail};
  assign rd_w = bus.addr == `UHP_ADDR_IER ? ier_q :
                bus.addr == `UHP_ADDR_IIR ? iir_w :
                bus.addr == `UHP_ADDR_LCR ? lcr_q :
                bus.addr == `UHP_ADDR_MCR ? mcr_q :
                bus.addr == `UHP_ADDR_LSR ? lsr_w :
                bus.addr == `UHP_ADDR_MSR ? msr_w :
                bus.addr == `UHP_ADDR_SCR ? scr_q : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ier_q <= `UHP_IER_RST;
      mcr_q <= `UHP_MCR_RST;
      scr_q <= `UHP_SCR_RST;
      lcr_q <= `UHP_LCR_RST;
    end else if (bus.wr_stb) begin
      if (bus.addr == `UHP_ADDR_IER) ier_q <= {4'h0, bus.wdata[3:0]};
      if (bus.addr == `UHP_ADDR_MCR) mcr_q <= bus.wdata;
      if (bus.addr == `UHP_ADDR_SCR) scr_q <= bus.wdata;
      if (bus.addr == `UHP_ADDR_LCR) lcr_q <= bus.wdata;
    end
  end

  // Event flags: a new event in the clearing cycle keeps the flag set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dsr_q  <= 1'b0;
      ddsr_q <= 1'b0;
      ls_q   <= 1'b0;
      tx_q   <= 1'b0;
      tx_lvl_q <= 1'b0;
    end else begin
      dsr_q  <= ~set_ready_n;
      ddsr_q <= ms_set | (ddsr_q & ~ms_clr);
      ls_q   <= ls_set | (ls_q & ~ls_clr);
      tx_lvl_q <= tx_space;
      tx_q   <= tx_set | (tx_q & ~tx_clr & tx_space);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.rdata    <= 8'h00;
      bus.irq      <= 1'b0;
      bus.irq_oe_n <= 1'b1;
      bus.dtr_n    <= 1'b1;
    end else begin
      if (bus.rd_stb) bus.rdata <= rd_w;
      bus.irq      <= pend;
      bus.irq_oe_n <= ~mcr_q[`UHP_MCR_IRQ_BIT];
      bus.dtr_n    <= ~mcr_q[`UHP_MCR_DTR_BIT];
    end
  end
endmodule
`default_nettype wire

/* File: uhp_host_port.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Eight-bit data bus driven only during reads, otherwise released.
// - Data bit 0 is the least significant and first serial bit.
// - Read strobe falling edge presents the addressed register on the bus.
// - Write strobe rising edge stores bus data into the addressed register.
// - Each channel has its own active-high interrupt output.
// - Interrupt output driven only while control bit 3 is set; sources enabled individually.
// - Sources: receiver errors, receive data, transmit space, modem status change.
// - After reset each interrupt output is released.
// - Writing 1 to control bit 0 drives terminal ready low.
// - Terminal ready goes high on writing 0, and after reset.
// - Modem ready input is sampled and shown in the status register.
// - Channel select 0 picks channel B, 1 picks channel A.
// - Strobes count only while the active-low chip select is low.
module uhp_host_port (
  input  wire logic       clk,              // 100 MHz clock.
  input  wire logic       nrst,             // Asynchronous reset, active low.
  input  wire logic       chip_select_n,    // Chip select, active low.
  input  wire logic       channel_select,   // 1 = channel A, 0 = channel B.
  input  wire logic [2:0] register_address, // Register address.
  input  wire logic       read_strobe_n,    // Read strobe, active low.
  input  wire logic       write_strobe_n,   // Write strobe, active low.
  input  wire logic [7:0] host_data_in,     // Data bus as seen at the pins.
  output logic      [7:0] host_data_out,    // Read data driven onto the bus.
  output logic            host_data_oe_n,   // Low while the bus is driven.
  output logic      [1:0] channel_irq,      // Interrupt, [1] = A, [0] = B.
  output logic      [1:0] channel_irq_oe_n, // Low while interrupt is driven.
  output logic      [1:0] terminal_ready_n, // Terminal ready, active low.
  input  wire logic [1:0] set_ready_n,      // Modem ready, active low.
  input  wire logic [1:0] rx_error,         // Receiver error events.
  input  wire logic [1:0] rx_avail,         // Receive data available.
  input  wire logic [1:0] tx_space          // Transmit space available.
);
  logic       rst_s1_q, rst_n_q;
  logic [1:0] rd_sync_q, wr_sync_q;
  logic       rd_q, wr_q, cs_hold_q, sel_q;
  logic [2:0] addr_q;
  logic [7:0] data_q;
  logic       rd_fall, wr_rise, rd_active;
  uhp_pkg::uhp_bus_e st_q, st_d;
  logic [7:0] ch_rdata [2];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobes arrive asynchronously; only the second and third stages feed edge logic.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      rd_sync_q <= 2'b11;
      wr_sync_q <= 2'b11;
      rd_q      <= 1'b1;
      wr_q      <= 1'b1;
    end else begin
      rd_sync_q <= {rd_sync_q[0], read_strobe_n};
      wr_sync_q <= {wr_sync_q[0], write_strobe_n};
      rd_q      <= rd_sync_q[1];
      wr_q      <= wr_sync_q[1];
    end
  end

  // Address and data are captured while the strobe is low; they are stable then.
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      addr_q    <= 3'h0;
      sel_q     <= 1'b0;
      cs_hold_q <= 1'b0;
      data_q    <= 8'h00;
    end else if (!rd_sync_q[1] || !wr_sync_q[1]) begin
      addr_q    <= register_address;
      sel_q     <= channel_select;
      cs_hold_q <= ~chip_select_n;
      data_q    <= host_data_in;
    end
  end

  assign rd_fall = rd_q & ~rd_sync_q[1] & ~chip_select_n;
  assign wr_rise = ~wr_q & wr_sync_q[1] & cs_hold_q;

  always_comb begin
    st_d = st_q;
    case (st_q)
      uhp_pkg::UHP_IDLE:  st_d = rd_fall ? uhp_pkg::UHP_READ : uhp_pkg::UHP_IDLE;
      uhp_pkg::UHP_READ:  st_d = rd_sync_q[1] ? uhp_pkg::UHP_IDLE : uhp_pkg::UHP_READ;
      default:            st_d = uhp_pkg::UHP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) st_q <= uhp_pkg::UHP_IDLE;
    else          st_q <= st_d;
  end

  // Read data are captured one cycle after the read edge inside the channel.
  assign rd_active = st_q == uhp_pkg::UHP_READ;

  ////////////////////////////////////////////////////////////////////////////
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      uhp_chan_if cif ();
      // Channel index 1 is A (select high), 0 is B (select low).
      assign cif.rd_stb = rd_fall & (channel_select == ch);
      assign cif.wr_stb = wr_rise & (sel_q == ch);
      assign cif.addr   = rd_fall ? register_address : addr_q;
      assign cif.wdata  = data_q;
      assign ch_rdata[ch]        = cif.rdata;
      assign channel_irq[ch]     = cif.irq;
      assign channel_irq_oe_n[ch] = cif.irq_oe_n;
      assign terminal_ready_n[ch] = cif.dtr_n;
      uhp_channel u_chan (
        .clk         (clk),
        .rst_n       (rst_n_q),
        .bus         (cif),
        .set_ready_n (set_ready_n[ch]),
        .rx_err      (rx_error[ch]),
        .rx_avail    (rx_avail[ch]),
        .tx_space    (tx_space[ch])
      );
    end
  endgenerate

  logic rd_sel_q;
  always_ff @(posedge clk or negedge rst_n_q) begin
    if (!rst_n_q) rd_sel_q <= 1'b0;
    else if (rd_fall) rd_sel_q <= channel_select;
  end

  // Bus is released as soon as the read strobe returns high or chip select goes high.
  assign host_data_out  = ch_rdata[rd_sel_q];
  assign host_data_oe_n = ~(rd_active & ~chip_select_n & ~read_strobe_n);
endmodule
`default_nettype wire

/* File: uhp_host_port_props.sv */
`timescale 1ns/1ps
`default_nettype none
module uhp_host_port_props (
  input wire logic       clk,              // Clock.
  input wire logic       nrst,             // Reset, active low.
  input wire logic       chip_select_n,    // Chip select, active low.
  input wire logic       read_strobe_n,    // Read strobe, active low.
  input wire logic       write_strobe_n,   // Write strobe, active low.
  input wire logic [7:0] host_data_out,    // Read data.
  input wire logic       host_data_oe_n,   // Data bus enable, active low.
  input wire logic [1:0] channel_irq,      // Interrupts.
  input wire logic [1:0] channel_irq_oe_n, // Interrupt enables, active low.
  input wire logic [1:0] terminal_ready_n  // Terminal ready, active low.
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [3:0] since_wr_q;
  // Control pins may only move within a few cycles of a write strobe ending.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) since_wr_q <= 4'hF;
    else if ($rose(write_strobe_n)) since_wr_q <= 4'h0;
    else if (since_wr_q != 4'hF) since_wr_q <= since_wr_q + 4'h1;
  end
  oe_needs_rd_a: assert property (!host_data_oe_n |-> !read_strobe_n && !chip_select_n)
    else $error("data bus driven outside a selected read");
  oe_idle_a: assert property (read_strobe_n |-> host_data_oe_n)
    else $error("data bus driven while read strobe high");
  rd_answer_a: assert property ($fell(read_strobe_n) && !chip_select_n ##1
    (!read_strobe_n && !chip_select_n) [*5] |-> !host_data_oe_n)
    else $error("read data not presented in time");
  rd_hold_a: assert property (!host_data_oe_n && !$past(host_data_oe_n) |-> $stable(host_data_out))
    else $error("read data changed while driven");
  rst_idle_a: assert property ($rose(nrst) |->
    terminal_ready_n == 2'h3 && channel_irq_oe_n == 2'h3 && channel_irq == 2'h0)
    else $error("outputs not idle after reset");
  dtr_move_a: assert property ($changed(terminal_ready_n) |-> since_wr_q < 4'h9)
    else $error("terminal ready moved without a write");
  irqoe_move_a: assert property ($changed(channel_irq_oe_n) |-> since_wr_q < 4'h9)
    else $error("interrupt enable moved without a write");
  cs_ignore_a: assert property (chip_select_n [*8] |->
    $stable(terminal_ready_n) && $stable(channel_irq_oe_n))
    else $error("deselected strobe changed state");
  cover property ($fell(host_data_oe_n));
  cover property ($fell(terminal_ready_n[1]));
  cover property ($rose(channel_irq[0]));
endmodule
bind uhp_host_port uhp_host_port_props u_props (.clk(clk), .nrst(nrst),
  .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
  .write_strobe_n(write_strobe_n), .host_data_out(host_data_out),
  .host_data_oe_n(host_data_oe_n), .channel_irq(channel_irq),
  .channel_irq_oe_n(channel_irq_oe_n), .terminal_ready_n(terminal_ready_n));
`default_nettype wire

/* File: uhp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module uhp_host_model (
  input  wire logic       clk,              // Clock.
  input  wire logic       bus_oe_n,         // Device drives the bus, active low.
  input  wire logic [7:0] bus_level,        // Level seen on the data bus.
  output logic            chip_select_n,    // Chip select, active low.
  output logic            channel_select,   // 1 = channel A, 0 = channel B.
  output logic      [2:0] register_address, // Register address.
  output logic            read_strobe_n,    // Read strobe, active low.
  output logic            write_strobe_n,   // Write strobe, active low.
  output logic      [7:0] bus_drive         // Data the host drives.
);
  initial begin
    chip_select_n = 1'b1;
    channel_select = 1'b0;
    register_address = 3'h0;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    bus_drive = 8'h00;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Released data shows the inverse of the last byte, so stale data never passes.
  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d, input logic cs);
    chip_select_n = cs;
    channel_select = ch;
    register_address = a;
    bus_drive = d;
    write_strobe_n = 1'b0;
    cyc(4);
    write_strobe_n = 1'b1;
    cyc(4);
    bus_drive = ~d;
    chip_select_n = 1'b1;
    // An idle cycle keeps a following call from moving chip select in the same step.
    cyc(1);
  endtask
  task automatic rd(input logic ch, input logic [2:0] a, output logic [7:0] d);
    int n;
    d = 8'hXX;
    chip_select_n = 1'b0;
    channel_select = ch;
    register_address = a;
    read_strobe_n = 1'b0;
    for (n = 0; n < 12 && bus_oe_n !== 1'b0; n++) cyc(1);
    cyc(3);
    if (bus_oe_n === 1'b0) d = bus_level;
    read_strobe_n = 1'b1;
    cyc(3);
    chip_select_n = 1'b1;
    cyc(1);
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "uhp_consts.svh"
module tb_top;
  logic       clk = 1'b0;
  logic       nrst = 1'b0;
  logic       cs_n, ch_sel, rd_n, wr_n, doe_n;
  logic [2:0] addr;
  logic [7:0] drv, dout, lvl, rv;
  logic [1:0] irq, irq_oe_n, dtr_n, dsr_n, rx_err, rx_av, tx_sp;
  int         error_cnt = 0;
  int         checks = 0;
  always #5 clk = ~clk;
  assign lvl = (doe_n === 1'b0) ? dout : drv;
  uhp_host_port dut (.clk(clk), .nrst(nrst), .chip_select_n(cs_n), .channel_select(ch_sel),
    .register_address(addr), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .host_data_in(lvl),
    .host_data_out(dout), .host_data_oe_n(doe_n), .channel_irq(irq), .channel_irq_oe_n(irq_oe_n),
    .terminal_ready_n(dtr_n), .set_ready_n(dsr_n), .rx_error(rx_err), .rx_avail(rx_av),
    .tx_space(tx_sp));
  uhp_host_model host (.clk(clk), .bus_oe_n(doe_n), .bus_level(lvl), .chip_select_n(cs_n),
    .channel_select(ch_sel), .register_address(addr), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .bus_drive(drv));
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    dsr_n = 2'h3;
    rx_err = 2'h0;
    rx_av = 2'h0;
    tx_sp = 2'h0;
    repeat (20) @(posedge clk);
    #1 nrst = 1'b1;
    host.cyc(3);
    chk("dtr", 8'h03, {6'h0, dtr_n});
    chk("irq_oe", 8'h03, {6'h0, irq_oe_n});
    chk("data_oe", 8'h01, {7'h0, doe_n});
    for (int c = 0; c < 2; c++) begin
      host.wr(1'(c), `UHP_ADDR_MCR, 8'h09, 1'b0);
      host.cyc(4);
      chk("dtr", c ? 8'h00 : 8'h02, {6'h0, dtr_n});
      chk("irq_oe", c ? 8'h00 : 8'h02, {6'h0, irq_oe_n});
      host.rd(1'(c), `UHP_ADDR_MCR, rv);
      chk("mcr", 8'h09, rv);
      host.wr(1'(c), `UHP_ADDR_SCR, c ? 8'h81 : 8'h7E, 1'b0);
    end
    for (int c = 0; c < 2; c++) begin
      host.rd(1'(c), `UHP_ADDR_SCR, rv);
      chk("scr", c ? 8'h81 : 8'h7E, rv);
      for (int k = 0; k < 4; k++) begin
        host.wr(1'(c), `UHP_ADDR_IER, 8'(1 << k), 1'b0);
        rx_av[c] = (k == 0);
        tx_sp[c] = (k == 1);
        rx_err[c] = (k == 2);
        if (k == 3) dsr_n[c] = 1'b0;
        host.cyc(1);
        rx_err[c] = 1'b0;
        host.cyc(8);
        chk("irq", 8'h01, {7'h0, irq[c]});
        host.wr(1'(c), `UHP_ADDR_IER, 8'h00, 1'b0);
        host.cyc(4);
        chk("irq_off", 8'h00, {7'h0, irq[c]});
      end
      host.rd(1'(c), `UHP_ADDR_MSR, rv);
      chk("msr", 8'h22, rv & 8'h22);
    end
    host.rd(1'b1, `UHP_ADDR_LSR, rv);
    chk("lsr", 8'h02, rv);
    host.rd(1'b1, `UHP_ADDR_LSR, rv);
    chk("lsr_clr", 8'h00, rv);
    dsr_n[1] = 1'b1;
    host.cyc(2);
    host.rd(1'b1, `UHP_ADDR_MSR, rv);
    chk("msr_drop", 8'h02, rv);
    host.rd(1'b1, `UHP_ADDR_MSR, rv);
    chk("msr_clr", 8'h00, rv);
    host.wr(1'b1, `UHP_ADDR_IER, 8'h02, 1'b0);
    tx_sp[1] = 1'b1;
    host.cyc(2);
    chk("irq_tx", 8'h01, {7'h0, irq[1]});
    host.rd(1'b1, `UHP_ADDR_IIR, rv);
    chk("iir", `UHP_IIR_TX, rv);
    host.rd(1'b1, `UHP_ADDR_IIR, rv);
    chk("iir_clr", `UHP_IIR_NONE, rv);
    tx_sp[1] = 1'b0;
    host.cyc(1);
    tx_sp[1] = 1'b1;
    host.cyc(2);
    chk("irq_tx2", 8'h01, {7'h0, irq[1]});
    host.wr(1'b1, `UHP_ADDR_DATA, 8'h55, 1'b0);
    host.rd(1'b1, `UHP_ADDR_IIR, rv);
    chk("iir_wr", `UHP_IIR_NONE, rv);
    chk("irq_clr", 8'h00, {7'h0, irq[1]});
    host.wr(1'b0, `UHP_ADDR_LCR, 8'hA5, 1'b0);
    host.rd(1'b0, `UHP_ADDR_LCR, rv);
    chk("lcr", 8'hA5, rv);
    host.rd(1'b1, `UHP_ADDR_LCR, rv);
    chk("lcr_a", 8'h00, rv);
    host.rd(1'b1, `UHP_ADDR_DATA, rv);
    chk("data", 8'h00, rv);
    host.wr(1'b1, `UHP_ADDR_MCR, 8'h00, 1'b0);
    host.cyc(4);
    chk("dtr", 8'h02, {6'h0, dtr_n});
    chk("irq_oe", 8'h02, {6'h0, irq_oe_n});
    host.wr(1'b1, `UHP_ADDR_MCR, 8'h09, 1'b1);
    host.cyc(10);
    chk("dtr_cs", 8'h02, {6'h0, dtr_n});
    tally_and_finish();
  end
endmodule
`default_nettype wire
